// *** logic/qdc_chan.v ***
// One converter channel: input register, output register and power-down flag
`timescale 1ns/10ps
`include "qdc_defs.vh"
module qdc_chan
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        clr_i,
  input  wire [15:0] clr_code_i,
  input  wire        write_i,
  input  wire        update_i,
  input  wire        pwr_up_i,
  input  wire        pwr_dn_i,
  input  wire [15:0] data_i,
  output reg  [15:0] in_reg_o,
  output reg  [15:0] out_reg_o,
  output reg         pd_o
);
  wire [15:0] next_in = write_i ? data_i : in_reg_o;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_reg_o  <= `QDC_ZERO_CODE;
      out_reg_o <= `QDC_ZERO_CODE;
      pd_o      <= 1'b0;
    end
    else if (clr_i)
    begin
      in_reg_o  <= clr_code_i;
      out_reg_o <= clr_code_i;
    end
    else
    begin
      in_reg_o <= next_in;
      // Update copies the input register, including a same-cycle write
      if (update_i)
        out_reg_o <= next_in;
      // Power-up wins over a power-down; contents are untouched
      if (pwr_up_i)
        pd_o <= 1'b0;
      else if (pwr_dn_i)
        pd_o <= 1'b1;
    end
  end
endmodule

// *** logic/qdc_defs.vh ***
// Constants for the quad converter serial command block
`ifndef QDC_DEFS_VH
`define QDC_DEFS_VH
`define QDC_WORD_BITS     32
`define QDC_CMD_WIDTH     4
`define QDC_ADDR_WIDTH    4
`define QDC_DATA_WIDTH    16
`define QDC_CMD_MSB       23
`define QDC_CMD_LSB       20
`define QDC_ADDR_MSB      19
`define QDC_ADDR_LSB      16
`define QDC_DATA_MSB      15
`define QDC_DATA_LSB      0
`define QDC_CMD_WRITE     4'h0
`define QDC_CMD_UPD       4'h1
`define QDC_CMD_WR_UPDALL 4'h2
`define QDC_CMD_WR_UPD    4'h3
`define QDC_CMD_PD        4'h4
`define QDC_CMD_PD_CHIP   4'h5
`define QDC_CMD_REF_INT   4'h6
`define QDC_CMD_REF_EXT   4'h7
`define QDC_CMD_NOP       4'hf
`define QDC_ADDR_ALL      4'hf
`define QDC_ZERO_CODE     16'h0000
`define QDC_MID_CODE      16'h8000
`define QDC_POR_FILL      3'h7
`endif

// *** logic/qdc_sync.v ***
// Two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/10ps
module qdc_sync
(
  input  wire clk_i,
  input  wire rst_i,
  input  wire init_i,
  input  wire d_i,
  output reg  q_o
);
  reg meta;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= init_i;
      q_o  <= init_i;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// *** logic/qdc_top.v ***
// Serial command control of a quad voltage-output converter
// Notes on behaviour
// R1: While strobe is low, serial bits shift into the shift register.
// R2: Strobe rising ends shifting and executes the shifted command.
// R3: Input data is sampled on rising serial clock edges only.
// R4: Words of 24 or 32 bits per strobe-low period are accepted.
// R5: Serial output shows bit 32 edges late, changed on falling edge.
// R6: Serial output is always driven, never high impedance.
// R7: Update pin falling with strobe high updates all output registers.
// R8: Update pin falling with strobe low defers update to strobe rising.
// R9: Update pin low powers up all channels regardless of strobe.
// R10: Update pin low at strobe rising blocks software power-down commands.
// R11: Clear low with select low sets all registers to zero.
// R12: Clear low with select high sets all registers to mid scale.
// R13: Power-on loads zero or mid scale by the select pin.
// R14: Internal reference is on after start-up; external select turns it off.
// R15: Codes 0000, 0010, 0011 write; 0010 updates all, 0011 one.
// R16: Code 0001 updates addressed channel; every update powers channels up.
// R17: Code 0100 powers down addressed channels; 0101 all plus reference.
// R18: 0110 selects internal reference, 0111 external, 1111 does nothing.
// R19: Addresses 0000-0011 are channels A-D, 1111 is all channels.
// R20: Word is command, address, 16-bit data, most significant first.
// R21: 32-bit words lead with eight ignored bits.
// R22: Update copies input register into the active output register.
// R23: Reference off by external select returns only by internal select.
// R24: Command decodes from the last 24 bits shifted in.
// R25: Per-channel and reference power-down flags, contents untouched.
`timescale 1ns/10ps
`include "qdc_defs.vh"
module qdc_top
(
  input  wire        SYS_CLK_I,
  input  wire        SRST_I,
  input  wire        SELECT_LOAD_STROBE_N_I,
  input  wire        SERIAL_CLK_I,
  input  wire        SERIAL_DATA_IN_I,
  input  wire        ASYNC_UPDATE_N_I,
  input  wire        ASYNC_CLEAR_N_I,
  input  wire        RESET_VALUE_SELECT_I,
  output reg         SERIAL_DATA_OUT_O,
  output reg  [15:0] OUT_CODE_A_O,
  output reg  [15:0] OUT_CODE_B_O,
  output reg  [15:0] OUT_CODE_C_O,
  output reg  [15:0] OUT_CODE_D_O,
  output reg  [3:0]  CHAN_POWER_DOWN_O,
  output reg         REF_POWER_DOWN_O,
  output reg         REF_EXTERNAL_O
);
  // Synchronised pins
  wire strobe_n;
  wire sclk;
  wire serial_data_in;
  wire upd_n;
  wire clr_n;
  wire rsel;

  qdc_sync u_sync_cs
  (
    .clk_i  (SYS_CLK_I),
    .rst_i  (SRST_I),
    .init_i (1'b1),
    .d_i    (SELECT_LOAD_STROBE_N_I),
    .q_o    (strobe_n)
  );
  qdc_sync u_sync_sck
  (
    .clk_i  (SYS_CLK_I),
    .rst_i  (SRST_I),
    .init_i (1'b0),
    .d_i    (SERIAL_CLK_I),
    .q_o    (sclk)
  );
  qdc_sync u_sync_sdi
  (
    .clk_i  (SYS_CLK_I),
    .rst_i  (SRST_I),
    .init_i (1'b0),
    .d_i    (SERIAL_DATA_IN_I),
    .q_o    (serial_data_in)
  );
  qdc_sync u_sync_upd
  (
    .clk_i  (SYS_CLK_I),
    .rst_i  (SRST_I),
    .init_i (1'b1),
    .d_i    (ASYNC_UPDATE_N_I),
    .q_o    (upd_n)
  );
  qdc_sync u_sync_clr
  (
    .clk_i  (SYS_CLK_I),
    .rst_i  (SRST_I),
    .init_i (1'b1),
    .d_i    (ASYNC_CLEAR_N_I),
    .q_o    (clr_n)
  );
  qdc_sync u_sync_rsel
  (
    .clk_i  (SYS_CLK_I),
    .rst_i  (SRST_I),
    .init_i (1'b0),
    .d_i    (RESET_VALUE_SELECT_I),
    .q_o    (rsel)
  );

  // Edge detection on synchronised levels
  reg sclk_d;
  reg strobe_d;
  reg upd_d;
  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      sclk_d   <= 1'b0;
      strobe_d <= 1'b1;
      upd_d    <= 1'b1;
    end
    else
    begin
      sclk_d   <= sclk;
      strobe_d <= strobe_n;
      upd_d    <= upd_n;
    end
  end
  wire sclk_rise   = sclk & ~sclk_d;
  wire sclk_fall   = ~sclk & sclk_d;
  wire strobe_rise = strobe_n & ~strobe_d;
  wire upd_fall    = ~upd_n & upd_d;

  // Power-on load, held until the select pin has crossed its synchroniser
  reg [2:0] por_sr;
  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      por_sr <= `QDC_POR_FILL;
    else
      por_sr <= {por_sr[1:0], 1'b0};
  end
  wire por_pending = |por_sr;

  // Shift register
  reg [31:0] shreg;
  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      shreg <= 32'h0000_0000;
    else if (!strobe_n && sclk_rise)                 // [R1] [R3] [R4] [R21]
      shreg <= {shreg[30:0], serial_data_in};
  end

  // Daisy-chain output, changed on falling edge, always driven
  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      SERIAL_DATA_OUT_O <= 1'b0;
    else if (sclk_fall)
      SERIAL_DATA_OUT_O <= shreg[31];                // [R5] [R6]
  end

  // Command fields from the last 24 bits
  wire [3:0]  cmd  = shreg[`QDC_CMD_MSB:`QDC_CMD_LSB];     // [R20] [R24]
  wire [3:0]  addr = shreg[`QDC_ADDR_MSB:`QDC_ADDR_LSB];
  wire [15:0] data = shreg[`QDC_DATA_MSB:`QDC_DATA_LSB];

  // Deferred update pending while strobe low
  reg upd_deferred;
  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      upd_deferred <= 1'b0;
    else if (strobe_rise)
      upd_deferred <= 1'b0;
    else if (upd_fall && !strobe_n)
      upd_deferred <= 1'b1;                          // [R8]
  end

  // Channel address decode
  reg [3:0] sel;
  always @*
  begin
    if (addr == `QDC_ADDR_ALL)
      sel = 4'hf;                                    // [R19]
    else if (addr[3:2] == 2'b00)
      sel = 4'h1 << addr[1:0];
    else
      sel = 4'h0;
  end

  // Command execution
  wire exec    = strobe_rise;                        // [R2]
  wire pd_inh  = ~upd_n;                             // [R10]
  wire pin_upd = (upd_fall && strobe_n && !strobe_rise)
               | (exec && (upd_deferred || !upd_n)); // [R7] [R8]
  reg  [3:0] wr;
  reg  [3:0] upd;
  reg  [3:0] pdn;
  reg        ref_on;
  reg        ref_off_ext;
  reg        ref_off_chip;
  always @*
  begin
    wr           = 4'h0;
    upd          = 4'h0;
    pdn          = 4'h0;
    ref_on       = 1'b0;
    ref_off_ext  = 1'b0;
    ref_off_chip = 1'b0;
    if (exec)
    begin
      case (cmd)
        `QDC_CMD_WRITE:     wr = sel;                // [R15]
        `QDC_CMD_UPD:       upd = sel;               // [R16] [R22]
        `QDC_CMD_WR_UPDALL:
        begin
          wr  = sel;
          upd = 4'hf;
        end
        `QDC_CMD_WR_UPD:
        begin
          wr  = sel;
          upd = sel;
        end
        `QDC_CMD_PD:        pdn = pd_inh ? 4'h0 : sel;  // [R17]
        `QDC_CMD_PD_CHIP:
        begin
          pdn          = pd_inh ? 4'h0 : 4'hf;
          ref_off_chip = ~pd_inh;
        end
        `QDC_CMD_REF_INT:   ref_on = 1'b1;           // [R18]
        `QDC_CMD_REF_EXT:   ref_off_ext = ~pd_inh;
        default:            wr = 4'h0;               // No operation
      endcase
    end
    if (pin_upd)
      upd = 4'hf;
  end
  wire [3:0] pwr_up = upd | (upd_n ? 4'h0 : 4'hf);  // [R9] [R16]

  // Clear and power-on value
  wire        clr_now  = ~clr_n | por_pending;       // [R11] [R12] [R13]
  wire [15:0] clr_code = rsel ? `QDC_MID_CODE : `QDC_ZERO_CODE;

  wire [15:0] out_a;
  wire [15:0] out_b;
  wire [15:0] out_c;
  wire [15:0] out_d;
  wire [3:0]  pd;

  qdc_chan u_ch_a
  (
    .clk_i      (SYS_CLK_I),
    .rst_i      (SRST_I),
    .clr_i      (clr_now),
    .clr_code_i (clr_code),
    .write_i    (wr[0]),
    .update_i   (upd[0]),
    .pwr_up_i   (pwr_up[0]),
    .pwr_dn_i   (pdn[0]),
    .data_i     (data),
    .in_reg_o   (),
    .out_reg_o  (out_a),
    .pd_o       (pd[0])
  );
  qdc_chan u_ch_b
  (
    .clk_i      (SYS_CLK_I),
    .rst_i      (SRST_I),
    .clr_i      (clr_now),
    .clr_code_i (clr_code),
    .write_i    (wr[1]),
    .update_i   (upd[1]),
    .pwr_up_i   (pwr_up[1]),
    .pwr_dn_i   (pdn[1]),
    .data_i     (data),
    .in_reg_o   (),
    .out_reg_o  (out_b),
    .pd_o       (pd[1])
  );
  qdc_chan u_ch_c
  (
    .clk_i      (SYS_CLK_I),
    .rst_i      (SRST_I),
    .clr_i      (clr_now),
    .clr_code_i (clr_code),
    .write_i    (wr[2]),
    .update_i   (upd[2]),
    .pwr_up_i   (pwr_up[2]),
    .pwr_dn_i   (pdn[2]),
    .data_i     (data),
    .in_reg_o   (),
    .out_reg_o  (out_c),
    .pd_o       (pd[2])
  );
  qdc_chan u_ch_d
  (
    .clk_i      (SYS_CLK_I),
    .rst_i      (SRST_I),
    .clr_i      (clr_now),
    .clr_code_i (clr_code),
    .write_i    (wr[3]),
    .update_i   (upd[3]),
    .pwr_up_i   (pwr_up[3]),
    .pwr_dn_i   (pdn[3]),
    .data_i     (data),
    .in_reg_o   (),
    .out_reg_o  (out_d),
    .pd_o       (pd[3])
  );

  // Reference state: off by chip power-down returns on any channel power-up
  reg ref_pd_chip;
  reg ref_pd_ext;
  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      ref_pd_chip <= 1'b0;                           // [R14]
      ref_pd_ext  <= 1'b0;
    end
    else
    begin
      if (ref_on || (|pwr_up))
        ref_pd_chip <= 1'b0;
      else if (ref_off_chip)
        ref_pd_chip <= 1'b1;                         // [R25]
      if (ref_on)
        ref_pd_ext <= 1'b0;                          // [R23]
      else if (ref_off_ext)
        ref_pd_ext <= 1'b1;                          // [R14]
    end
  end

  // Registered outputs
  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      OUT_CODE_A_O      <= `QDC_ZERO_CODE;
      OUT_CODE_B_O      <= `QDC_ZERO_CODE;
      OUT_CODE_C_O      <= `QDC_ZERO_CODE;
      OUT_CODE_D_O      <= `QDC_ZERO_CODE;
      CHAN_POWER_DOWN_O <= 4'h0;
      REF_POWER_DOWN_O  <= 1'b0;
      REF_EXTERNAL_O    <= 1'b0;
    end
    else
    begin
      OUT_CODE_A_O      <= out_a;
      OUT_CODE_B_O      <= out_b;
      OUT_CODE_C_O      <= out_c;
      OUT_CODE_D_O      <= out_d;
      CHAN_POWER_DOWN_O <= pd;
      REF_POWER_DOWN_O  <= ref_pd_chip | ref_pd_ext;
      REF_EXTERNAL_O    <= ref_pd_ext;
    end
  end
endmodule

// *** tb/qdc_host.sv ***
// Host model driving the serial command link
`timescale 1ns/10ps
module qdc_host
(
  input  wire clk_i,
  input  wire dout_i,
  output reg  strobe_n_o,
  output reg  sck_o,
  output reg  din_o
);
  reg [31:0] cap;
  initial
  begin
    strobe_n_o = 1'b1;
    sck_o = 1'b0;
    din_o = 1'b0;
    cap = 32'h0;
  end
  task wt(input integer n);
    repeat (n) @(negedge clk_i);
  endtask
  // Sends the low nbits of w first bit first; clock idles low between frames
  task send(input [31:0] w, input integer nbits);
    integer i;
    begin
      strobe_n_o = 1'b0;
      wt(4);
      for (i = nbits - 1; i >= 0; i = i - 1)
      begin
        din_o = w[i];
        wt(4);
        sck_o = 1'b1;
        wt(2);
        cap = {cap[30:0], dout_i};
        wt(2);
        sck_o = 1'b0;
      end
      wt(4);
      strobe_n_o = 1'b1;
      din_o = ~din_o;
      wt(20);
    end
  endtask
endmodule

// *** tb/qdc_props.sv ***
// Checker of port relations for the serial command block
`timescale 1ns/10ps
module qdc_props
(
  input wire        SYS_CLK_I,
  input wire        SRST_I,
  input wire        SELECT_LOAD_STROBE_N_I,
  input wire        SERIAL_CLK_I,
  input wire        ASYNC_UPDATE_N_I,
  input wire        ASYNC_CLEAR_N_I,
  input wire        RESET_VALUE_SELECT_I,
  input wire        SERIAL_DATA_OUT_O,
  input wire [15:0] OUT_CODE_A_O,
  input wire [15:0] OUT_CODE_B_O,
  input wire [15:0] OUT_CODE_C_O,
  input wire [15:0] OUT_CODE_D_O,
  input wire [3:0]  CHAN_POWER_DOWN_O,
  input wire        REF_POWER_DOWN_O,
  input wire        REF_EXTERNAL_O
);
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SRST_I);
  wire [63:0] codes = {OUT_CODE_A_O, OUT_CODE_B_O, OUT_CODE_C_O, OUT_CODE_D_O};
  property p_dout_fall;
    $changed(SERIAL_DATA_OUT_O) |-> !$past(SERIAL_CLK_I);
  endproperty
  a_dout_fall: assert property (p_dout_fall) else $error("serial out moved, clock high");
  property p_quiet;
    (SELECT_LOAD_STROBE_N_I && ASYNC_UPDATE_N_I && ASYNC_CLEAR_N_I)[*8] |=>
      $stable(codes) && $stable({CHAN_POWER_DOWN_O, REF_POWER_DOWN_O, REF_EXTERNAL_O});
  endproperty
  a_quiet: assert property (p_quiet) else $error("state moved without a command");
  property p_clear_zero;
    (!ASYNC_CLEAR_N_I && !RESET_VALUE_SELECT_I)[*8] |-> codes == 64'h0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear to zero failed");
  property p_clear_mid;
    (!ASYNC_CLEAR_N_I && RESET_VALUE_SELECT_I)[*8] |-> codes == {4{16'h8000}};
  endproperty
  a_clear_mid: assert property (p_clear_mid) else $error("clear to mid scale failed");
  property p_upd_pwr;
    (!ASYNC_UPDATE_N_I)[*6] |-> CHAN_POWER_DOWN_O == 4'h0 && (REF_EXTERNAL_O || !REF_POWER_DOWN_O);
  endproperty
  a_upd_pwr: assert property (p_upd_pwr) else $error("update pin low left power down");
  property p_pd_rise;
    (CHAN_POWER_DOWN_O & ~$past(CHAN_POWER_DOWN_O)) != 4'h0 |->
      $past(ASYNC_UPDATE_N_I, 2) && $past(SELECT_LOAD_STROBE_N_I, 2);
  endproperty
  a_pd_rise: assert property (p_pd_rise) else $error("power down while update low");
  property p_ext_rose;
    $rose(REF_EXTERNAL_O) |-> $past(ASYNC_UPDATE_N_I, 2);
  endproperty
  a_ext_rose: assert property (p_ext_rose) else $error("external select while update low");
  property p_ext_hold;
    REF_EXTERNAL_O |-> REF_POWER_DOWN_O;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("internal ref on with external");
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the serial command block
`timescale 1ns/10ps
module tb_top;
  reg         clk;
  reg         srst;
  reg         upd_n;
  reg         clear_n;
  reg         rsel;
  wire        strobe_n;
  wire        sck;
  wire        din;
  wire        dout;
  wire [15:0] code [0:3];
  wire [3:0]  pd;
  wire        ref_pd;
  wire        ref_ext;
  integer     n_fail;
  integer     num_checks;
  reg  [15:0] ex [0:3];
  reg  [3:0]  ex_pd;
  reg         ex_rpd;
  reg         ex_ext;
  qdc_host host (.clk_i(clk), .dout_i(dout), .strobe_n_o(strobe_n), .sck_o(sck), .din_o(din));
  qdc_top DUT (.SYS_CLK_I(clk), .SRST_I(srst), .SELECT_LOAD_STROBE_N_I(strobe_n),
    .SERIAL_CLK_I(sck), .SERIAL_DATA_IN_I(din), .ASYNC_UPDATE_N_I(upd_n),
    .ASYNC_CLEAR_N_I(clear_n), .RESET_VALUE_SELECT_I(rsel), .SERIAL_DATA_OUT_O(dout),
    .OUT_CODE_A_O(code[0]), .OUT_CODE_B_O(code[1]), .OUT_CODE_C_O(code[2]),
    .OUT_CODE_D_O(code[3]), .CHAN_POWER_DOWN_O(pd), .REF_POWER_DOWN_O(ref_pd),
    .REF_EXTERNAL_O(ref_ext));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input string name, input [15:0] e, input [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        n_fail = n_fail + 1;
        $display("MISMATCH %s expected %h seen %h", name, e, g);
      end
    end
  endtask
  task chk_all(input string tname);
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        chk($sformatf("code%0d", k), ex[k], code[k]);
      chk("chan_pd", {12'h0, ex_pd}, {12'h0, pd});
      chk("ref_pd", {15'h0, ex_rpd}, {15'h0, ref_pd});
      chk("ref_ext", {15'h0, ex_ext}, {15'h0, ref_ext});
      $display("test %s done", tname);
    end
  endtask
  task cmd(input [3:0] c, input [3:0] a, input [15:0] d);
    host.send({8'h00, c, a, d}, 24);
  endtask
  task upd_pulse;
    begin
      upd_n = 1'b0;
      repeat (10) @(negedge clk);
      upd_n = 1'b1;
      repeat (10) @(negedge clk);
    end
  endtask
  task clear_pulse(input sel);
    begin
      rsel = sel;
      repeat (4) @(negedge clk);
      clear_n = 1'b0;
      repeat (12) @(negedge clk);
      clear_n = 1'b1;
      repeat (10) @(negedge clk);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Tests take about 4100 clocks; this limit is far beyond that
  initial
  begin
    #1000000;
    n_fail = n_fail + 1;
    final_report;
  end
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    srst = 1'b1;
    upd_n = 1'b1;
    clear_n = 1'b0;
    rsel = 1'b0;
    ex = '{16'h0, 16'h0, 16'h0, 16'h0};
    {ex_pd, ex_rpd, ex_ext} = 6'h0;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (12) @(negedge clk);
    clear_n = 1'b1;
    repeat (10) @(negedge clk);
    chk_all("power_on");
    cmd(4'h0, 4'h0, 16'h1234);
    chk_all("write_only");
    cmd(4'h1, 4'h0, 16'h0);
    ex[0] = 16'h1234;
    chk_all("update_a");
    host.send({8'hff, 4'h3, 4'h1, 16'h5678}, 32);
    ex[1] = 16'h5678;
    chk_all("padded_word");
    cmd(4'h0, 4'h3, 16'hffff);
    chk_all("write_d_only");
    cmd(4'h0, 4'h2, 16'h9abc);
    cmd(4'h2, 4'h3, 16'hdef0);
    ex[2] = 16'h9abc;
    ex[3] = 16'hdef0;
    chk_all("write_update_all");
    cmd(4'h4, 4'hf, 16'h0);
    ex_pd = 4'hf;
    chk_all("pd_all");
    cmd(4'h1, 4'h0, 16'h0);
    ex_pd = 4'he;
    chk_all("update_powers_up");
    cmd(4'h5, 4'h0, 16'h0);
    cmd(4'hf, 4'h0, 16'h7777);
    {ex_pd, ex_rpd} = 5'h1f;
    chk_all("chip_pd_nop");
    upd_pulse;
    {ex_pd, ex_rpd} = 5'h0;
    chk_all("pin_power_up");
    cmd(4'h7, 4'h0, 16'h0);
    {ex_rpd, ex_ext} = 2'b11;
    chk_all("ext_ref");
    upd_pulse;
    chk_all("pin_keeps_ext");
    cmd(4'h6, 4'h0, 16'h0);
    {ex_rpd, ex_ext} = 2'b00;
    chk_all("int_ref");
    cmd(4'h0, 4'h0, 16'h1111);
    upd_pulse;
    ex[0] = 16'h1111;
    chk_all("pin_update");
    fork
      cmd(4'h0, 4'h1, 16'h2222);
      begin
        repeat (20) @(negedge clk);
        upd_n = 1'b0;
      end
    join
    upd_n = 1'b1;
    repeat (20) @(negedge clk);
    ex[1] = 16'h2222;
    chk_all("pin_deferred");
    fork
      cmd(4'h4, 4'hf, 16'h0);
      begin
        repeat (20) @(negedge clk);
        upd_n = 1'b0;
      end
    join
    upd_n = 1'b1;
    repeat (20) @(negedge clk);
    chk_all("pd_blocked");
    host.send(32'ha5f03c96, 32);
    host.send(32'h00f00000, 32);
    chk("dout_hi", 16'ha5f0, host.cap[31:16]);
    chk("dout_lo", 16'h3c96, host.cap[15:0]);
    $display("test dout_chain done");
    clear_pulse(1'b1);
    ex = '{16'h8000, 16'h8000, 16'h8000, 16'h8000};
    chk_all("clear_mid");
    clear_pulse(1'b0);
    ex = '{16'h0, 16'h0, 16'h0, 16'h0};
    chk_all("clear_zero");
    final_report;
  end
endmodule
bind qdc_top qdc_props u_props (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I),
  .SELECT_LOAD_STROBE_N_I(SELECT_LOAD_STROBE_N_I), .SERIAL_CLK_I(SERIAL_CLK_I),
  .ASYNC_UPDATE_N_I(ASYNC_UPDATE_N_I), .ASYNC_CLEAR_N_I(ASYNC_CLEAR_N_I),
  .RESET_VALUE_SELECT_I(RESET_VALUE_SELECT_I), .SERIAL_DATA_OUT_O(SERIAL_DATA_OUT_O),
  .OUT_CODE_A_O(OUT_CODE_A_O), .OUT_CODE_B_O(OUT_CODE_B_O), .OUT_CODE_C_O(OUT_CODE_C_O),
  .OUT_CODE_D_O(OUT_CODE_D_O), .CHAN_POWER_DOWN_O(CHAN_POWER_DOWN_O),
  .REF_POWER_DOWN_O(REF_POWER_DOWN_O), .REF_EXTERNAL_O(REF_EXTERNAL_O));
